// ### hdl/abu_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Enabled unit breaks on full 16-bit match
// - Writing 0 or reset clears enable
// - Hardware sets active flag on match
// - Software writing active 1 raises break
// - Handler writes 0; reset clears active
// - Compare address from high, low bytes
// - Reset clears both address byte registers
// - Clear-enable gates status clears during break
// - No match breaks in low-power modes
module abu_top #(
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Cpu internal bus
    input wire abu_pkg::abu_cpu_bus_t cpu_bus,
    input wire logic cpu_in_break,
    // Status-clear requests from other modules
    input wire logic status_clear_req,
    // Outputs to cpu and peripherals
    output logic break_irq,
    output logic status_clear_allow,
    output logic irq
);
    // Register state
    logic break_enable_bit_ff, nxt_break_enable_bit;
    logic break_active_flag_ff, nxt_break_active_flag;
    logic break_clear_flag_enable_ff, nxt_break_clear_flag_enable;
    logic [7:0] breakpoint_addr_high_ff, nxt_breakpoint_addr_high;
    logic [7:0] breakpoint_addr_low_ff, nxt_breakpoint_addr_low;
    logic [1:0] irq_status_ff, nxt_irq_status;
    logic [1:0] irq_mask_ff, nxt_irq_mask;
    // Outputs
    logic break_irq_ff, nxt_break_irq;
    logic clr_allow_ff, nxt_clr_allow;
    logic irq_ff, nxt_irq;
    // Bus slave state
    logic aw_ff, nxt_aw;
    logic w_ff, nxt_w;
    logic [AW-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic wstrb0_ff, nxt_wstrb0;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    // Ready flags, registered so the ports come straight from flops
    logic awready_ff, wready_ff, arready_ff;
    // Strobes
    logic wr_do, rd_do, match_hit, soft_break;

    // Comparator: live address against programmed breakpoint
    abu_cmp #(
        .WIDTH(16)
    ) u_cmp (
        .aclk(aclk),
        .aresetn(aresetn),
        .addr(cpu_bus.addr),
        .ref_addr({breakpoint_addr_high_ff, breakpoint_addr_low_ff}),
        .qualify(break_enable_bit_ff && cpu_bus.valid && !cpu_bus.low_power),
        .hit(match_hit)
    );

    assign wr_do = aw_ff && w_ff && !bvalid_ff;
    assign rd_do = s_axi_arvalid && !rvalid_ff;
    assign soft_break = wr_do && wstrb0_ff && (awaddr_ff[7:0] == abu_pkg::OFF_STATUS_CONTROL)
        && wdata_ff[abu_pkg::BIT_ACTIVE];

    // Write channel capture and response
    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb0 = wstrb0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        // Take address when slot free
        if (s_axi_awvalid && !aw_ff) begin
            nxt_aw = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        // Take data when slot free
        if (s_axi_wvalid && !w_ff) begin
            nxt_w = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb0 = s_axi_wstrb[0];
        end
        // Both present: commit and answer
        if (wr_do) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bvalid = 1'b1;
            if (awaddr_ff[7:0] > abu_pkg::OFF_IRQ_MASK || awaddr_ff[1:0] != 2'b00) begin
                nxt_bresp = abu_pkg::RST_RESP_SLVERR;
            end else begin
                nxt_bresp = abu_pkg::RST_RESP_OKAY;
            end
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    // Write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= abu_pkg::RST_RESP_OKAY;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            // Slot empty next cycle means ready next cycle
            awready_ff <= !nxt_aw;
            wready_ff <= !nxt_w;
        end
    end

    // Register file next state
    always_comb begin
        nxt_break_enable_bit = break_enable_bit_ff;
        nxt_break_active_flag = break_active_flag_ff;
        nxt_break_clear_flag_enable = break_clear_flag_enable_ff;
        nxt_breakpoint_addr_high = breakpoint_addr_high_ff;
        nxt_breakpoint_addr_low = breakpoint_addr_low_ff;
        nxt_irq_status = irq_status_ff;
        nxt_irq_mask = irq_mask_ff;
        // Software writes, low byte lane only
        if (wr_do && wstrb0_ff) begin
            if (awaddr_ff[7:0] == abu_pkg::OFF_STATUS_CONTROL) begin
                nxt_break_enable_bit = wdata_ff[abu_pkg::BIT_ENABLE];
                nxt_break_active_flag = wdata_ff[abu_pkg::BIT_ACTIVE];
            end else if (awaddr_ff[7:0] == abu_pkg::OFF_ADDR_HIGH) begin
                nxt_breakpoint_addr_high = wdata_ff[7:0];
            end else if (awaddr_ff[7:0] == abu_pkg::OFF_ADDR_LOW) begin
                nxt_breakpoint_addr_low = wdata_ff[7:0];
            end else if (awaddr_ff[7:0] == abu_pkg::OFF_CLEAR_ENABLE) begin
                nxt_break_clear_flag_enable = wdata_ff[0];
            end else if (awaddr_ff[7:0] == abu_pkg::OFF_IRQ_MASK) begin
                nxt_irq_mask = wdata_ff[1:0];
            end
        end
        // Reading the interrupt status clears it
        if (rd_do && s_axi_araddr[7:0] == abu_pkg::OFF_IRQ_STATUS) begin
            nxt_irq_status = 2'b00;
        end
        // Match and software-break events win over clears
        if (match_hit) begin
            nxt_break_active_flag = 1'b1;
            nxt_irq_status[abu_pkg::IRQ_MATCH] = 1'b1;
        end
        if (soft_break) begin
            nxt_irq_status[abu_pkg::IRQ_SOFT] = 1'b1;
        end
    end

    // Register file flops; reset clears everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            break_enable_bit_ff <= 1'b0;
            break_active_flag_ff <= 1'b0;
            break_clear_flag_enable_ff <= 1'b0;
            breakpoint_addr_high_ff <= abu_pkg::RST_BYTE;
            breakpoint_addr_low_ff <= abu_pkg::RST_BYTE;
            irq_status_ff <= 2'b00;
            irq_mask_ff <= 2'b00;
        end else begin
            break_enable_bit_ff <= nxt_break_enable_bit;
            break_active_flag_ff <= nxt_break_active_flag;
            break_clear_flag_enable_ff <= nxt_break_clear_flag_enable;
            breakpoint_addr_high_ff <= nxt_breakpoint_addr_high;
            breakpoint_addr_low_ff <= nxt_breakpoint_addr_low;
            irq_status_ff <= nxt_irq_status;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // Output next values
    always_comb begin
        nxt_break_irq = nxt_break_active_flag;
        nxt_clr_allow = status_clear_req && (!cpu_in_break || break_clear_flag_enable_ff);
        nxt_irq = |(nxt_irq_status & nxt_irq_mask);
    end

    // Output flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            break_irq_ff <= 1'b0;
            clr_allow_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            break_irq_ff <= nxt_break_irq;
            clr_allow_ff <= nxt_clr_allow;
            irq_ff <= nxt_irq;
        end
    end

    // Read channel
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rd_do) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = abu_pkg::RST_RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            if (s_axi_araddr[1:0] != 2'b00) begin
                nxt_rresp = abu_pkg::RST_RESP_SLVERR;
            end else if (s_axi_araddr[7:0] == abu_pkg::OFF_STATUS_CONTROL) begin
                nxt_rdata[abu_pkg::BIT_ENABLE] = break_enable_bit_ff;
                nxt_rdata[abu_pkg::BIT_ACTIVE] = break_active_flag_ff;
            end else if (s_axi_araddr[7:0] == abu_pkg::OFF_ADDR_HIGH) begin
                nxt_rdata[7:0] = breakpoint_addr_high_ff;
            end else if (s_axi_araddr[7:0] == abu_pkg::OFF_ADDR_LOW) begin
                nxt_rdata[7:0] = breakpoint_addr_low_ff;
            end else if (s_axi_araddr[7:0] == abu_pkg::OFF_CLEAR_ENABLE) begin
                nxt_rdata[0] = break_clear_flag_enable_ff;
            end else if (s_axi_araddr[7:0] == abu_pkg::OFF_IRQ_STATUS) begin
                nxt_rdata[1:0] = irq_status_ff;
            end else if (s_axi_araddr[7:0] == abu_pkg::OFF_IRQ_MASK) begin
                nxt_rdata[1:0] = irq_mask_ff;
            end else begin
                nxt_rresp = abu_pkg::RST_RESP_SLVERR;
            end
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Read channel flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= abu_pkg::RST_RESP_OKAY;
            arready_ff <= 1'b1;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            // One read in flight: ready only while no data waits
            arready_ff <= !nxt_rvalid;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign break_irq = break_irq_ff;
    assign status_clear_allow = clr_allow_ff;
    assign irq = irq_ff;
endmodule
`default_nettype wire

// ### common/abu_pkg.sv
`default_nettype none
package abu_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFF_CLEAR_ENABLE = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    // Field positions in the status and control register
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    // Interrupt status bit positions
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_SOFT = 1;
    localparam int IRQ_BITS = 2;
    // Reset byte value and bus response codes
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_RESP_OKAY = 2'h0;
    localparam logic [1:0] RST_RESP_SLVERR = 2'h2;

    // Cpu-side bus cycle status
    typedef struct packed {
        logic [15:0] addr;
        logic valid;
        logic low_power;
    } abu_cpu_bus_t;
endpackage
`default_nettype wire

// ### hdl/abu_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// Registered 16-bit address comparator
module abu_cmp #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Compare operands
    input wire logic [WIDTH-1:0] addr,
    input wire logic [WIDTH-1:0] ref_addr,
    input wire logic qualify,
    // Result
    output logic hit
);
    logic hit_ff;
    logic nxt_hit;

    // Full-width equality, gated by the qualifier
    always_comb begin
        nxt_hit = qualify && (addr == ref_addr);
    end

    // Register the result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_ff <= 1'b0;
        end else begin
            hit_ff <= nxt_hit;
        end
    end

    assign hit = hit_ff;
endmodule
`default_nettype wire

// ### verification/abu_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks beside the break unit
module abu_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Cpu side
    input wire abu_pkg::abu_cpu_bus_t cpu_bus,
    input wire logic cpu_in_break,
    input wire logic status_clear_req,
    input wire logic break_irq,
    input wire logic status_clear_allow
);
    // Address cycle that is allowed to match
    wire logic live = cpu_bus.valid && !cpu_bus.low_power;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Bus handshake steps
    sequence aw_take; s_axi_awvalid && s_axi_awready; endsequence
    sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
    write_resp_a: assert property (aw_take |-> ##[1:3] s_axi_bvalid)
        else $error("no write response");
    write_busy_a: assert property (aw_take |=> !s_axi_awready)
        else $error("address slot not held");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("response kept");
    read_resp_a: assert property (ar_take |=> s_axi_rvalid)
        else $error("no read data");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data kept");
    byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
        else $error("upper read bits set");
    clear_pass_a: assert property (status_clear_req && !cpu_in_break |=> status_clear_allow)
        else $error("clear lost");
    clear_idle_a: assert property (!status_clear_req |=> !status_clear_allow)
        else $error("stray clear");
    break_cause_a: assert property ($rose(break_irq) |-> s_axi_bvalid || $past(live, 2))
        else $error("break without cause");
endmodule
bind abu_top abu_checker abu_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .cpu_bus, .cpu_in_break, .status_clear_req, .break_irq, .status_clear_allow);
`default_nettype wire

// ### verification/abu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Cpu internal bus: one address cycle per request
module abu_cpu_model (
    // Clock
    input wire logic aclk,
    // Request from the bench
    input wire logic go,
    input wire logic [15:0] addr,
    input wire logic low_power,
    // Bus toward the unit
    output var abu_pkg::abu_cpu_bus_t cpu_bus
);
    initial cpu_bus = '0;
    // Each idle cycle inverts the address the bus showed the cycle before so a stale value cannot match by luck
    always @(posedge aclk) begin
        cpu_bus.valid <= go;
        cpu_bus.addr <= go ? addr : ~cpu_bus.addr;
        cpu_bus.low_power <= low_power;
    end
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Bus master and cpu-side stimulus
    logic aclk = '0, aresetn = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, h, l;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0, s_axi_bready = '1, s_axi_rready = '1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic cpu_in_break = '0, status_clear_req = '0, break_irq, status_clear_allow, irq, go = '0, lp = '0;
    logic [15:0] ca = '0, bp;
    abu_pkg::abu_cpu_bus_t cpu_bus;
    int err_count = 0, cmp_count = 0;
    // 100 MHz clock
    always #5 aclk = ~aclk;
    abu_top abu_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cpu_bus, .cpu_in_break, .status_clear_req, .break_irq, .status_clear_allow, .irq);
    abu_cpu_model abu_cpu_model_inst (.aclk, .go, .addr(ca), .low_power(lp), .cpu_bus);
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic bchk(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask
    // Expected status and control word
    function automatic logic [31:0] sc(input logic en, input logic act);
        return ({31'h0, en} << abu_pkg::BIT_ENABLE) | ({31'h0, act} << abu_pkg::BIT_ACTIVE);
    endfunction
    // One write; address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = abu_pkg::RST_RESP_OKAY);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= '0;
            n++;
        end while (!s_axi_bvalid && n < 20);
        bchk(s_axi_bvalid, '1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    // One read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = abu_pkg::RST_RESP_OKAY);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= '0;
            n++;
        end while (!s_axi_rvalid && n < 20);
        bchk(s_axi_rvalid, '1);
        v = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    // One cpu address cycle, then the break line
    task automatic hit(input logic [15:0] a, input logic p, input logic want);
        ca <= a;
        lp <= p;
        go <= '1;
        @(posedge aclk);
        go <= '0;
        repeat (4) @(posedge aclk);
        bchk(break_irq, want);
    endtask
    // One status-clear attempt; the grant stands one cycle
    task automatic clr(input logic brk, input logic want);
        cpu_in_break <= brk;
        status_clear_req <= '1;
        @(posedge aclk);
        status_clear_req <= '0;
        @(posedge aclk);
        bchk(status_clear_allow, want);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Hang guard, far beyond the fewer than 200 cycles the run needs
    initial begin
        #50000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(6));
        repeat (10) @(posedge aclk);
        aresetn <= '1;
        // Random breakpoint bytes read back
        repeat (3) begin
            h = $urandom;
            l = $urandom;
            wr(8'h04, h);
            wr(8'h08, l);
            rd(8'h04, d);
            chk(d, {24'h00_0000, h[7:0]});
            rd(8'h08, d);
            chk(d, {24'h00_0000, l[7:0]});
        end
        // Low byte lane off: the write is answered but leaves the register alone
        s_axi_wstrb <= 4'he;
        wr(8'h04, ~h);
        s_axi_wstrb <= 4'hf;
        rd(8'h04, d);
        chk(d, {24'h00_0000, h[7:0]});
        bp = {h[7:0], l[7:0]};
        // Near misses, low power, then a real match
        wr(8'h14, 32'h0000_0003);
        wr(8'h00, sc('1, '0));
        hit(bp ^ 16'h8000, '0, '0);
        hit(bp ^ 16'h0001, '0, '0);
        hit(bp, '1, '0);
        hit(bp, '0, '1);
        rd(8'h00, d);
        chk(d, sc('1, '1));
        bchk(irq, '1);
        rd(8'h10, d);
        chk(d, 32'h0000_0001 << abu_pkg::IRQ_MATCH);
        repeat (3) @(posedge aclk);
        bchk(irq, '0);
        wr(8'h00, sc('1, '0));
        bchk(break_irq, '0);
        wr(8'h00, sc('0, '0));
        hit(bp, '0, '0);
        // Software break under both masks
        wr(8'h14, 32'h0000_0001);
        wr(8'h00, sc('0, '1));
        bchk(break_irq, '1);
        repeat (2) @(posedge aclk);
        bchk(irq, '0);
        wr(8'h14, 32'h0000_0002);
        repeat (2) @(posedge aclk);
        bchk(irq, '1);
        rd(8'h10, d);
        chk(d, 32'h0000_0001 << abu_pkg::IRQ_SOFT);
        wr(8'h00, sc('0, '0));
        // Status clears gated during break
        clr('1, '0);
        clr('0, '1);
        wr(8'h0c, 32'h0000_0001);
        clr('1, '1);
        // Refused places
        wr(8'h18, 32'h0000_00ff, abu_pkg::RST_RESP_SLVERR);
        wr(8'h02, 32'h0000_00ff, abu_pkg::RST_RESP_SLVERR);
        rd(8'h18, d, abu_pkg::RST_RESP_SLVERR);
        chk(d, '0);
        // Second reset with everything set
        wr(8'h00, sc('1, '1));
        aresetn <= '0;
        repeat (2) @(posedge aclk);
        aresetn <= '1;
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i), d);
            chk(d, '0);
        end
        bchk(break_irq, '0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
